// ---- pkg/rspd_pkg.sv ----
// Constants and carrier types for the reset-state and power-down block.
// Assumes one 200 MHz core clock; the watchdog tick arrives as a pin.
package rspd_pkg;

    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned SYS_OSC_MHZ    = 6;
    // Enable every 34 cycles: rounded up, so slightly under 6 MHz, never over
    localparam int unsigned SYS_DIV        = (CLK_MHZ + SYS_OSC_MHZ - 1) / SYS_OSC_MHZ;
    localparam int unsigned WDT_WIDTH      = 13;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PCL_RESET       = 8'h00;
    localparam logic [7:0] PORT_RESET      = 8'hFF;
    localparam logic [6:0] INTERRUPT_CONTROL_REG_RESET      = 7'h00;
    localparam logic [2:0] WATCHDOG_RATE_SELECT_RESET      = 3'h7;
    localparam logic [7:0] SYSTEM_CONTROL_REG_RESET      = 8'h40;
    localparam logic [7:0] PTR_RESET       = 8'h00;
    localparam logic [7:0] STACK_RESET     = 8'h00;
    localparam int unsigned PORT_COUNT     = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SRC_NONE,
        SRC_POWER_ON,
        SRC_WDT_RUN,
        SRC_PIN_RUN,
        SRC_PIN_HALT,
        SRC_WDT_HALT
    } rspd_src_type;

    typedef struct packed
    {
        logic [7:0] data;
        logic [7:0] dir;
    } rspd_port_type;

    typedef struct packed
    {
        logic [6:0] interruptControl;
        logic [2:0] watchdogRate;
        logic [7:0] systemControl;
        logic [7:0] periodTimer;
    } rspd_ctrl_type;

    typedef struct packed
    {
        logic [7:0] accumulator;
        logic [7:0] tablePointer;
        logic [7:0] memoryPointerZero;
        logic [7:0] memoryPointerOne;
    } rspd_ptr_type;

endpackage

// ---- verilog/rspd_clk_div.sv ----
// Divider making the system-clock enable from the core clock.
// Assumes clk is free running; run low freezes the divider.
module rspd_clk_div
#(
    parameter int unsigned DIV = rspd_pkg::SYS_DIV
)
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic run,
    output logic      tick
);
    import rspd_pkg::*;

    // Counter is 16 bits wide, so very slow enables are refused
    if (DIV < 2 || DIV > 65536)
    begin
        $error("DIV must lie between 2 and 65536");
    end

    logic [15:0] count;
    logic [15:0] next_count;

    always_comb
    begin
        next_count = count;
        if (run)
        begin
            next_count = (count == 16'(DIV - 1)) ? 16'h0000 : 16'(count + 16'h0001);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            count <= 16'h0000;
        else
            count <= next_count;
    end

    // Gating by run keeps the system clock dead in power-down
    assign tick = run && (count == 16'(DIV - 1));
endmodule

// ---- verilog/rspd_core.sv ----
// Reset-state loading and power-down entry for a small 8-bit core.
// Assumes pin inputs are asynchronous; core writes arrive as strobes.
module rspd_core
(
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    externalResetPin,
    input  wire logic                    watchdogOscTick,
    input  wire logic                    watchdogOptionEnable,
    input  wire logic                    haltExecute,
    input  wire logic                    clearWatchdog,
    input  wire logic                    wakeEvent,
    input  wire logic                    portWrite,
    input  wire logic [2:0]              portSelect,
    input  wire rspd_pkg::rspd_port_type portWriteData,
    input  wire logic                    ctrlWrite,
    input  wire rspd_pkg::rspd_ctrl_type ctrlWriteData,
    input  wire logic                    ptrWrite,
    input  wire rspd_pkg::rspd_ptr_type  ptrWriteData,
    output logic [7:0]                   program_counter_low,
    output logic [7:0]                   stackPointer,
    output logic                         power_down_flag,
    output logic                         watchdog_timeout_flag,
    output rspd_pkg::rspd_port_type      ports [5],
    output rspd_pkg::rspd_ctrl_type      ctrl,
    output rspd_pkg::rspd_ptr_type       pointers,
    output logic                         powerDown,
    output logic                         sysClockEnable,
    output logic                         watchdogOscRun,
    output logic [12:0]                  watchdogCount
);
    import rspd_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] resetSync;
    logic [1:0] wdtSync;
    logic       wdtLast;
    logic       wdtEdge;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            resetSync <= 2'b11;
            wdtSync   <= 2'b00;
            wdtLast   <= 1'b0;
        end
        else
        begin
            resetSync <= {resetSync[0], externalResetPin};
            wdtSync   <= {wdtSync[0], watchdogOscTick};
            wdtLast   <= wdtSync[1];
        end
    end

    assign wdtEdge = wdtSync[1] && !wdtLast;

    // ------------------------------------------------------------
    // Reset source record
    // ------------------------------------------------------------
    rspd_src_type source;
    rspd_src_type next_source;
    logic         wdtOverflow;
    logic         pinLow;

    assign pinLow = !resetSync[1];

    // Pin held low keeps the source pending until release
    always_comb
    begin
        next_source = SRC_NONE;
        if (pinLow)
            next_source = powerDown ? SRC_PIN_HALT : SRC_PIN_RUN;
        else if (source == SRC_POWER_ON || source == SRC_PIN_HALT || source == SRC_PIN_RUN)
            next_source = SRC_NONE;
        else if (wdtOverflow)
            next_source = powerDown ? SRC_WDT_HALT : SRC_WDT_RUN;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            source <= SRC_POWER_ON;
        else
            source <= next_source;
    end

    logic applyReset;
    logic fullReset;
    assign applyReset = !pinLow && (source != SRC_NONE);
    assign fullReset  = applyReset && (source != SRC_WDT_HALT);

    // ------------------------------------------------------------
    // Power-down and watchdog
    // ------------------------------------------------------------
    logic        next_powerDown;
    logic [12:0] next_watchdogCount;

    assign watchdogOscRun = watchdogOptionEnable;
    assign wdtOverflow = watchdogOscRun && ctrl.watchdogRate != 3'h0 && wdtEdge
                         && (watchdogCount == {13{1'b1}})
                         && !(powerDown && ctrl.periodTimer != 8'h00);

    always_comb
    begin
        next_powerDown     = powerDown;
        next_watchdogCount = watchdogCount;
        if (applyReset)
        begin
            next_powerDown     = 1'b0;
            next_watchdogCount = 13'h0000;
        end
        else if (haltExecute && !powerDown)
        begin
            next_powerDown     = 1'b1;
            next_watchdogCount = 13'h0000;
        end
        else
        begin
            if (powerDown && wakeEvent)
                next_powerDown = 1'b0;
            if (clearWatchdog && !powerDown)
                next_watchdogCount = 13'h0000;
            else if (watchdogOscRun && wdtEdge)
                next_watchdogCount = 13'(watchdogCount + 13'h0001);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            powerDown     <= 1'b0;
            watchdogCount <= 13'h0000;
        end
        else
        begin
            powerDown     <= next_powerDown;
            watchdogCount <= next_watchdogCount;
        end
    end

    rspd_clk_div u_div
    (
        .clk  (clk),
        .nrst (nrst),
        .run  (!powerDown && !pinLow),
        .tick (sysClockEnable)
    );

    // ------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------
    logic [7:0]    next_pcl;
    logic [7:0]    next_sp;
    logic          next_pdf;
    logic          next_to;
    rspd_port_type next_ports [5];
    rspd_ctrl_type next_ctrl;
    rspd_ptr_type  next_ptrs;

    // Writes are gated by powerDown and lose to reset and halt, not gated by the system clock, so power-down freezes all
    always_comb
    begin
        next_pcl   = program_counter_low;
        next_sp    = stackPointer;
        next_pdf   = power_down_flag;
        next_to    = watchdog_timeout_flag;
        next_ports = ports;
        next_ctrl  = ctrl;
        next_ptrs  = pointers;
        if (applyReset)
        begin
            next_pcl = PCL_RESET;
            next_sp  = STACK_RESET;
            case (source)
                SRC_POWER_ON:
                begin
                    next_pdf = 1'b0;
                    next_to  = 1'b0;
                end
                SRC_WDT_RUN:  next_to = 1'b1;
                SRC_PIN_HALT:
                begin
                    next_pdf = 1'b1;
                    next_to  = 1'b0;
                end
                SRC_WDT_HALT:
                begin
                    next_pdf = 1'b1;
                    next_to  = 1'b1;
                end
                default:      next_pdf = power_down_flag;
            endcase
            if (fullReset)
            begin
                for (int i = 0; i < PORT_COUNT; i++)
                    next_ports[i] = '{data: PORT_RESET, dir: PORT_RESET};
                next_ctrl = '{interruptControl: INTERRUPT_CONTROL_REG_RESET, watchdogRate: WATCHDOG_RATE_SELECT_RESET,
                              systemControl: SYSTEM_CONTROL_REG_RESET, periodTimer: PTR_RESET};
            end
            // Kept through every reset source; only nrst forces them, to zero
            next_ptrs = pointers;
        end
        else if (haltExecute && !powerDown)
        begin
            next_pdf = 1'b1;
            next_to  = 1'b0;
        end
        else if (!powerDown)
        begin
            if (clearWatchdog)
            begin
                next_pdf = 1'b0;
                next_to  = 1'b0;
            end
            if (portWrite && portSelect < 3'(PORT_COUNT))
                next_ports[portSelect] = portWriteData;
            if (ctrlWrite)
                next_ctrl = ctrlWriteData;
            if (ptrWrite)
                next_ptrs = ptrWriteData;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            program_counter_low   <= PCL_RESET;
            stackPointer          <= STACK_RESET;
            power_down_flag       <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
            for (int i = 0; i < PORT_COUNT; i++)
                ports[i] <= '{data: PORT_RESET, dir: PORT_RESET};
            ctrl     <= '{interruptControl: INTERRUPT_CONTROL_REG_RESET, watchdogRate: WATCHDOG_RATE_SELECT_RESET,
                          systemControl: SYSTEM_CONTROL_REG_RESET, periodTimer: PTR_RESET};
            pointers <= '0;
        end
        else
        begin
            program_counter_low   <= next_pcl;
            stackPointer          <= next_sp;
            power_down_flag       <= next_pdf;
            watchdog_timeout_flag <= next_to;
            ports                 <= next_ports;
            ctrl                  <= next_ctrl;
            pointers              <= next_ptrs;
        end
    end
endmodule

// ---- tb/rspd_checker.sv ----
// Port checker for rspd_core: power-down entry and reset loading.
// Assumes one clock domain with an asynchronous active-low reset.
module rspd_checker
(
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire logic                    externalResetPin,
    input wire logic                    watchdogOptionEnable,
    input wire logic                    haltExecute,
    input wire logic [7:0]              stackPointer,
    input wire logic                    power_down_flag,
    input wire logic                    watchdog_timeout_flag,
    input wire rspd_pkg::rspd_port_type ports [5],
    input wire rspd_pkg::rspd_ctrl_type ctrl,
    input wire logic                    powerDown,
    input wire logic                    sysClockEnable,
    input wire logic                    watchdogOscRun,
    input wire logic [12:0]             watchdogCount
);
    import rspd_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ----
    // Assertions
    // ----
    a_halt_enters_down: assert property (haltExecute && !powerDown && externalResetPin
        |=> powerDown && power_down_flag && !watchdog_timeout_flag) else $error("bad halt");
    a_halt_clears_count: assert property (haltExecute && !powerDown
        |=> watchdogCount == 13'h0) else $error("count not cleared");
    a_down_only_halt: assert property ($rose(powerDown) |-> $past(haltExecute))
        else $error("power-down without halt");
    a_down_no_clock: assert property (powerDown |-> !sysClockEnable)
        else $error("clock ran in power-down");
    a_osc_option: assert property (watchdogOscRun == watchdogOptionEnable)
        else $error("oscillator run mismatch");
    // Pin held high long enough that no pin reset load can land here
    a_down_holds: assert property (externalResetPin[*6] ##0 powerDown ##1 powerDown
        |-> $stable(ports[0]) && $stable(ports[1]) && $stable(ports[2]) && $stable(ports[3])
            && $stable(ports[4]) && $stable(ctrl)) else $error("state moved");
    a_wdt_off_frozen: assert property (!watchdogOptionEnable
        |=> watchdogCount <= $past(watchdogCount)) else $error("watchdog ran while disabled");
    a_pin_ports: assert property (!externalResetPin[*4] ##1 externalResetPin
        |-> ##[1:4] ports[0] == {PORT_RESET, PORT_RESET}) else $error("ports not set");
    a_pin_ctrl: assert property (!externalResetPin[*4] ##1 externalResetPin
        |-> ##[1:4] ctrl == {INTERRUPT_CONTROL_REG_RESET, WATCHDOG_RATE_SELECT_RESET, SYSTEM_CONTROL_REG_RESET, PTR_RESET})
        else $error("ctrl not reloaded");
    a_pin_halt_flags: assert property ((powerDown && !externalResetPin)[*4]
        ##1 externalResetPin |-> ##[1:4] power_down_flag && !watchdog_timeout_flag)
        else $error("halted pin flags wrong");
    a_halt_timeout: assert property ($rose(watchdog_timeout_flag) && $past(powerDown)
        |-> stackPointer == 8'h00 && power_down_flag) else $error("halted timeout wrong");
    c_halt: cover property (haltExecute ##1 powerDown);
    c_halt_timeout: cover property ($rose(watchdog_timeout_flag) && $past(powerDown));
    c_run_timeout: cover property ($rose(watchdog_timeout_flag) && !$past(powerDown));
endmodule

bind rspd_core rspd_checker i_chk (.clk, .nrst, .externalResetPin, .watchdogOptionEnable,
    .haltExecute, .stackPointer, .power_down_flag, .watchdog_timeout_flag, .ports, .ctrl,
    .powerDown, .sysClockEnable, .watchdogOscRun, .watchdogCount);

// ---- tb/tb_rspd_core.sv ----
// Self-checking bench for rspd_core, driving its ports directly.
// Assumes the watchdog tick may be made here from the core clock.
module tb_rspd_core;
    timeunit 1ns;
    timeprecision 1ps;
    import rspd_pkg::*;
    logic clk = 0, nrst = 1, externalResetPin = 1, watchdogOscTick = 0;
    logic watchdogOptionEnable = 1, haltExecute = 0, clearWatchdog = 0, wakeEvent = 0;
    logic portWrite = 0, ctrlWrite = 0, ptrWrite = 0, tickOn = 0;
    logic [2:0] portSelect = 3'h0;
    rspd_port_type portWriteData = '0;
    rspd_ctrl_type ctrlWriteData = '0;
    rspd_ptr_type  ptrWriteData = 32'h1122_3344;
    logic [7:0] program_counter_low, stackPointer;
    logic power_down_flag, watchdog_timeout_flag, powerDown, sysClockEnable, watchdogOscRun;
    logic [12:0] watchdogCount;
    rspd_port_type ports [5];
    rspd_ctrl_type ctrl;
    rspd_ptr_type  pointers;
    int n_mismatch = 0, num_checks = 0;
    localparam rspd_ctrl_type CtrlInit = {INTERRUPT_CONTROL_REG_RESET, WATCHDOG_RATE_SELECT_RESET, SYSTEM_CONTROL_REG_RESET, PTR_RESET};
    localparam rspd_port_type PortInit = {PORT_RESET, PORT_RESET};
    rspd_core i_dut (.clk, .nrst, .externalResetPin, .watchdogOscTick, .watchdogOptionEnable,
        .haltExecute, .clearWatchdog, .wakeEvent, .portWrite, .portSelect, .portWriteData,
        .ctrlWrite, .ctrlWriteData, .ptrWrite, .ptrWriteData, .program_counter_low,
        .stackPointer, .power_down_flag, .watchdog_timeout_flag, .ports, .ctrl, .pointers,
        .powerDown, .sysClockEnable, .watchdogOscRun, .watchdogCount);
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Tick slow enough for the two-flop sync to see every edge
    initial
    begin
        forever
        begin
            repeat (2) @(posedge clk);
            #1 watchdogOscTick = tickOn & ~watchdogOscTick;
        end
    end
    // ----
    // Helpers
    // ----
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        step(1);
        s = 0;
        step(1);
    endtask
    task automatic wr_port(input int i, input rspd_port_type v);
        portSelect = 3'(i);
        portWriteData = v;
        pulse(portWrite);
    endtask
    task automatic pin_reset;
        externalResetPin = 0;
        step(6);
        externalResetPin = 1;
        step(6);
    endtask
    task automatic wait_timeout;
        int i;
        tickOn = 1;
        for (i = 0; i < 40000 && watchdog_timeout_flag !== 1'b1; i++)
            step(1);
        tickOn = 0;
        step(3);
        if (i == 40000)
        begin
            n_mismatch++;
            $display("mismatch at %0t: watchdog timeout never came", $time);
            conclude();
        end
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        chk(program_counter_low, PCL_RESET);
        chk({watchdog_timeout_flag, power_down_flag}, 2'h0);
        for (int k = 0; k < 5; k++)
            chk(ports[k], PortInit);
        chk(ctrl, CtrlInit);
        $display("test reset done");
    endtask
    task automatic t_clock(input int cycles, input int exp);
        int n = 0;
        repeat (cycles)
        begin
            step(1);
            n += int'(sysClockEnable);
        end
        chk(n, exp);
    endtask
    task automatic t_halt;
        wr_port(2, 16'h5AA5);
        ctrlWriteData = {7'h2A, 3'h2, 8'h12, 8'h00};
        pulse(ctrlWrite);
        pulse(ptrWrite);
        pulse(haltExecute);
        chk({powerDown, watchdog_timeout_flag, power_down_flag}, 3'h5);
        wr_port(2, 16'h0000);
        chk(ports[2], 16'h5AA5);
        t_clock(50, 0);
        pulse(wakeEvent);
        chk({powerDown, ports[2], ctrl}, {1'b0, 16'h5AA5, ctrlWriteData});
        $display("test halt done");
    endtask
    task automatic t_timeouts;
        wait_timeout();
        chk({watchdog_timeout_flag, power_down_flag}, 2'h3);
        chk({ports[2], ctrl, pointers}, {PortInit, CtrlInit, ptrWriteData});
        wr_port(1, 16'h0F0F);
        pin_reset();
        chk({watchdog_timeout_flag, power_down_flag}, 2'h3);
        chk({ports[1], pointers}, {PortInit, ptrWriteData});
        wr_port(4, 16'h3C3C);
        pulse(haltExecute);
        pin_reset();
        chk({watchdog_timeout_flag, power_down_flag, ports[4]}, {2'h1, PortInit});
        pulse(clearWatchdog);
        chk({watchdogCount, watchdog_timeout_flag, power_down_flag}, 15'h0000);
        $display("test pin and running timeout done");
    endtask
    task automatic t_halt_timeout;
        wr_port(3, 16'hA5A5);
        ctrlWriteData = {7'h11, 3'h3, 8'h21, 8'h00};
        pulse(ctrlWrite);
        pulse(haltExecute);
        watchdogOptionEnable = 0;
        tickOn = 1;
        step(100);
        chk({watchdogCount, watchdogOscRun}, 14'h0);
        watchdogOptionEnable = 1;
        wait_timeout();
        chk({watchdog_timeout_flag, power_down_flag}, 2'h3);
        chk({program_counter_low, stackPointer}, 16'h0000);
        chk({ports[3], ctrl}, {16'hA5A5, ctrlWriteData});
        $display("test halted timeout done");
    endtask
    initial
    begin
        // Reset falls after time zero so the asynchronous branch sees an edge
        #1 nrst = 0;
        step(4);
        nrst = 1;
        step(2);
        t_reset();
        t_clock(340, 340 / SYS_DIV);
        t_halt();
        t_timeouts();
        t_halt_timeout();
        conclude();
    end
endmodule
